// *** src/slpx_pkg.sv ***
/*
  Package for the power-down instruction execution block: opcode, phase
  encoding, register bus map, status and event layout.
  Assumes a 14-bit instruction word and a 40 MHz core clock.
*/
`default_nettype none
package slpx_pkg;
  // Instruction word
  localparam int INSN_W = 14;
  localparam logic [13:0] OPC_POWERDOWN = 14'h0063;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;
  localparam logic [7:0] WDT_CLEAR = 8'h00;
  localparam logic [7:0] PRE_CLEAR = 8'h00;

  // Register bus
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_EVT = 4'h2;
  localparam logic [3:0] REG_EVT_CLR = 4'h3;
  localparam logic [3:0] REG_EVT_EN = 4'h4;

  // Control register fields
  localparam int CTRL_WAKE = 0;
  // Status register fields
  localparam int ST_TIMEOUT_N = 0;
  localparam int ST_POWERDOWN_N = 1;
  localparam int ST_HALTED = 2;
  // Event fields
  localparam int EVT_SLEEP_ENTER = 0;
  localparam int EVT_WAKE = 1;
  localparam int EVT_W = 2;

  // Reset values: both status flags read one after power-up
  localparam logic TIMEOUT_N_RST = 1'b1;
  localparam logic POWERDOWN_N_RST = 1'b1;
  localparam logic [1:0] EVT_RST = 2'h0;

  // Instruction phases, Gray along decode, nop, nop, sleep
  typedef enum logic [1:0] {
    SLPX_IDLE = 2'b00,
    SLPX_NOP1 = 2'b01,
    SLPX_NOP2 = 2'b11,
    SLPX_HALT = 2'b10
  } slpx_state_t;

  typedef struct packed {
    logic clear_wdt;
    logic clear_pre;
  } slpx_wdt_ctl_t;

  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } slpx_flags_t;
endpackage
`default_nettype wire

// *** src/slpx_core.sv ***
/*
  Execution logic for the power-down instruction, with a small register port.
  Holds the phase sequencer, the two status flags, the watchdog counter and
  prescaler with their clear pulses, the oscillator run level, sticky events
  with an enable mask and a level interrupt.
  Assumes the decoder presents one instruction word with a one-cycle valid,
  that the watchdog unit and oscillator control sit outside on the same clock,
  and that software wakes the core through the control register, since no
  other wake source is modelled here.
*/
// Local design decisions: the plain strobed port and the address map.
// Overview of operation
// RQ1: Power-down instruction clears power-down flag.
// RQ2: Power-down instruction sets time-out flag.
// RQ3: Power-down instruction zeroes watchdog and prescaler.
// RQ4: Afterwards halt and stop main oscillator.
`timescale 1ns/1ps
`default_nettype none
module slpx_core
  import slpx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction decoder
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn_word,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Watchdog unit
  output slpx_wdt_ctl_t wdt_ctl,
  output logic [WDT_W-1:0] watchdog_counter,
  output logic [PRE_W-1:0] watchdog_prescaler,
  // Status flags
  output slpx_flags_t flags,
  // Oscillator control and core halt
  output logic osc_run,
  output logic core_halted,
  // Interrupt
  output logic irq
);

  // Phase sequencer and halt indication
  slpx_state_t state_q;
  slpx_state_t state_d;
  logic halted_q;
  logic halted_d;
  logic osc_q;
  logic osc_d;
  logic wake_q;
  logic wake_d;
  logic enter_halt;
  logic leave_halt;
  logic is_sleep;

  // Status flags, active-low meaning
  slpx_flags_t flags_q;
  slpx_flags_t flags_d;

  // Watchdog counter, prescaler and one-cycle clear pulses
  slpx_wdt_ctl_t wctl_q;
  slpx_wdt_ctl_t wctl_d;
  logic [WDT_W-1:0] wdt_q;
  logic [WDT_W-1:0] wdt_d;
  logic [PRE_W-1:0] pre_q;
  logic [PRE_W-1:0] pre_d;

  // Event status, enable mask and interrupt level
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] evt_d;
  logic [EVT_W-1:0] en_q;
  logic [EVT_W-1:0] en_d;
  logic irq_q;
  logic irq_d;

  // Read data, nonzero only in the cycle after a read strobe
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // Write strobe aimed at one register of the map
  function automatic logic wr_hit(logic wr, logic [ADDR_W-1:0] addr,
                                  logic [ADDR_W-1:0] target);
    return wr && (addr == target);
  endfunction

  // Place an event-wide value in the low bits of a read word
  function automatic logic [DATA_W-1:0] evt_word(logic [EVT_W-1:0] v);
    logic [DATA_W-1:0] w;
    w = '0;
    w[EVT_W-1:0] = v;
    return w;
  endfunction

  // Status word: flag levels and halt indication at their field positions
  function automatic logic [DATA_W-1:0] status_word(slpx_flags_t f, logic halted);
    logic [DATA_W-1:0] w;
    w = '0;
    w[ST_TIMEOUT_N] = f.timeout_flag_n;
    w[ST_POWERDOWN_N] = f.powerdown_flag_n;
    w[ST_HALTED] = halted;
    return w;
  endfunction

  // Wrapping increments for the prescaler and the counter
  function automatic logic [PRE_W-1:0] pre_inc(logic [PRE_W-1:0] v);
    return v + {{(PRE_W-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic [WDT_W-1:0] wdt_inc(logic [WDT_W-1:0] v);
    return v + {{(WDT_W-1){1'b0}}, 1'b1};
  endfunction

  // Only an idle core takes the word; words during the sequence are dropped
  assign is_sleep = insn_valid && (insn_word == OPC_POWERDOWN) && (state_q == SLPX_IDLE);

  // Wake request is registered so a write never races the halt decode
  always_comb begin
    wake_d = wr_hit(reg_wr, reg_addr, REG_CTRL) && reg_wdata[CTRL_WAKE];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // Phase sequencer: decode, two idle phases, then halt
  always_comb begin
    state_d = state_q;
    osc_d = osc_q;
    enter_halt = 1'b0;
    leave_halt = 1'b0;
    unique case (state_q)
      SLPX_IDLE: begin
        if (is_sleep) begin
          state_d = SLPX_NOP1;
        end
      end
      SLPX_NOP1: begin
        state_d = SLPX_NOP2;
      end
      SLPX_NOP2: begin
        // RQ4: halt, stop oscillator
        state_d = SLPX_HALT;
        osc_d = 1'b0;
        enter_halt = 1'b1;
      end
      SLPX_HALT: begin
        if (wake_q) begin
          state_d = SLPX_IDLE;
          osc_d = 1'b1;
          leave_halt = 1'b1;
        end
      end
    endcase
    // Halt indication has its own flop so the port comes straight from one
    halted_d = (state_d == SLPX_HALT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SLPX_IDLE;
      halted_q <= 1'b0;
      osc_q <= 1'b1;
    end else begin
      state_q <= state_d;
      halted_q <= halted_d;
      osc_q <= osc_d;
    end
  end

  // Status flags change only on a taken power-down word
  always_comb begin
    flags_d = flags_q;
    if (is_sleep) begin
      // RQ1: clear power-down flag
      flags_d.powerdown_flag_n = 1'b0;
      // RQ2: set time-out flag
      flags_d.timeout_flag_n = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_q <= '{timeout_flag_n: TIMEOUT_N_RST, powerdown_flag_n: POWERDOWN_N_RST};
    end else begin
      flags_q <= flags_d;
    end
  end

  // Watchdog: counts while the core runs, cleared by a taken power-down word
  always_comb begin
    wctl_d = '0;
    wdt_d = wdt_q;
    pre_d = pre_q;
    if (is_sleep) begin
      // RQ3: zero watchdog, prescaler
      wdt_d = WDT_CLEAR;
      pre_d = PRE_CLEAR;
      wctl_d.clear_wdt = 1'b1;
      wctl_d.clear_pre = 1'b1;
    end else if (osc_q && (state_q == SLPX_IDLE)) begin
      // Frozen through the sequence and the halt, so the cleared value stands
      pre_d = pre_inc(pre_q);
      if (&pre_q) begin
        wdt_d = wdt_inc(wdt_q);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wctl_q <= '0;
      wdt_q <= WDT_CLEAR;
      pre_q <= PRE_CLEAR;
    end else begin
      wctl_q <= wctl_d;
      wdt_q <= wdt_d;
      pre_q <= pre_d;
    end
  end

  // Sticky events, enable mask and level interrupt
  always_comb begin
    evt_set = '0;
    evt_set[EVT_SLEEP_ENTER] = enter_halt;
    evt_set[EVT_WAKE] = leave_halt;
    en_d = en_q;
    evt_d = evt_q;
    if (wr_hit(reg_wr, reg_addr, REG_EVT_EN)) begin
      en_d = reg_wdata[EVT_W-1:0];
    end
    if (wr_hit(reg_wr, reg_addr, REG_EVT_CLR)) begin
      evt_d = evt_q & ~reg_wdata[EVT_W-1:0];
    end
    // Set wins over a same-cycle clear, so no event is ever lost
    evt_d = evt_d | evt_set;
    irq_d = |(evt_d & en_d);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      evt_q <= EVT_RST;
      en_q <= EVT_RST;
      irq_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  // Read mux; unmapped or write-only addresses read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: begin
          rdata_d = status_word(flags_q, halted_q);
        end
        REG_EVT: begin
          rdata_d = evt_word(evt_q);
        end
        REG_EVT_EN: begin
          rdata_d = evt_word(en_q);
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Every port comes straight from a flop
  assign reg_rdata = rdata_q;
  assign wdt_ctl = wctl_q;
  assign watchdog_counter = wdt_q;
  assign watchdog_prescaler = pre_q;
  assign flags = flags_q;
  assign osc_run = osc_q;
  assign core_halted = halted_q;
  assign irq = irq_q;

endmodule // slpx_core
`default_nettype wire

// *** dv/slpx_core_monitor.sv ***
/* Assertions on slpx_core ports.
   Assumes one clk domain, rst synchronous active high. */
`timescale 1ns/1ps
`default_nettype none
module slpx_core_monitor
  import slpx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic [WDT_W-1:0] watchdog_counter,
  input wire logic [PRE_W-1:0] watchdog_prescaler,
  input wire slpx_flags_t flags,
  input wire logic osc_run,
  input wire logic core_halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Busy window: words in the two cycles after a taken one are ignored
  logic [1:0] busy_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 2'h0;
    end else if (insn_valid && insn_word == OPC_POWERDOWN && osc_run && busy_q == 2'h0) begin
      busy_q <= 2'h2;
    end else if (busy_q != 2'h0) begin
      busy_q <= busy_q - 2'h1;
    end
  end
  sequence s_take;
    insn_valid && insn_word == OPC_POWERDOWN && osc_run && busy_q == 2'h0;
  endsequence
  sequence s_halt;
    !osc_run && core_halted;
  endsequence
  a_pd_clear: assert property (s_take |=> !flags.powerdown_flag_n)
    else $error("powerdown flag not cleared");
  a_to_set: assert property (s_take |=> flags.timeout_flag_n)
    else $error("timeout flag not set");
  a_wdt_zero: assert property (s_take |=> watchdog_counter == WDT_CLEAR
    && watchdog_prescaler == PRE_CLEAR) else $error("watchdog not cleared");
  a_halt_osc: assert property (s_take |-> ##3 s_halt)
    else $error("no halt three cycles after power-down");
endmodule // slpx_core_monitor
bind slpx_core slpx_core_monitor i_mon (.clk, .rst, .insn_valid, .insn_word,
  .watchdog_counter, .watchdog_prescaler, .flags, .osc_run, .core_halted);
`default_nettype wire

// *** dv/slpx_core_bench.sv ***
/* Bench for slpx_core: reset, foreign word, power-down, status, irq.
   Assumes the monitor is bound beside the design. */
`timescale 1ns/1ps
`default_nettype none
module slpx_core_bench
  import slpx_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic insn_valid = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [INSN_W-1:0] insn_word = 14'h0000;
  logic [ADDR_W-1:0] reg_addr = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic [DATA_W-1:0] reg_rdata;
  logic [WDT_W-1:0] watchdog_counter;
  logic [PRE_W-1:0] watchdog_prescaler;
  slpx_wdt_ctl_t wdt_ctl;
  slpx_flags_t flags;
  logic osc_run;
  logic core_halted;
  logic irq;
  int errors = 0;
  int n_tests = 0;
  localparam slpx_flags_t FLAGS_RST = '{timeout_flag_n: TIMEOUT_N_RST,
                                        powerdown_flag_n: POWERDOWN_N_RST};
  localparam slpx_flags_t FLAGS_SLEPT = '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b0};

  slpx_core i_dut (
    .clk(clk),
    .rst(rst),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .wdt_ctl(wdt_ctl),
    .watchdog_counter(watchdog_counter),
    .watchdog_prescaler(watchdog_prescaler),
    .flags(flags),
    .osc_run(osc_run),
    .core_halted(core_halted),
    .irq(irq)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // Compare tasks, one per kind of result
  task automatic chk_flags(string nm, slpx_flags_t e);
    n_tests++;
    if (flags !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, e, flags);
    end
  endtask
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Register port: one-cycle strobes, read data in the following cycle
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ins(logic [13:0] w);
    @(posedge clk);
    insn_word <= w;
    insn_valid <= 1'h1;
    @(posedge clk);
    insn_valid <= 1'h0;
    #1;
  endtask
  task automatic conclude;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    conclude;
  end
  // Scenario: hold reset for n edges, then check the reset state
  task automatic sc_reset(int n);
    logic [DATA_W-1:0] d;
    @(posedge clk);
    rst <= 1'h1;
    repeat (n) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk_flags("flags after reset", FLAGS_RST);
    chk_bit("osc_run after reset", 1'h1, osc_run);
    chk_bit("core_halted after reset", 1'h0, core_halted);
    chk_bit("irq after reset", 1'h0, irq);
    chk_byte("watchdog after reset", WDT_CLEAR, watchdog_counter);
    rd(REG_EVT, d);
    chk_byte("events after reset", 8'h00, d);
    rd(REG_EVT_EN, d);
    chk_byte("enable after reset", 8'h00, d);
  endtask

  // Scenario: a foreign word and an unmapped read change nothing
  task automatic sc_foreign();
    logic [DATA_W-1:0] d;
    ins(14'h0064);
    chk_flags("flags after foreign word", FLAGS_RST);
    chk_bit("clear_wdt after foreign word", 1'h0, wdt_ctl.clear_wdt);
    rd(4'hF, d);
    chk_byte("unmapped read", 8'h00, d);
  endtask

  // Scenario: power-down word, flags, watchdog clear and halt timing
  task automatic sc_sleep();
    logic [DATA_W-1:0] d;
    ins(OPC_POWERDOWN);
    chk_flags("flags after power-down", FLAGS_SLEPT);
    chk_byte("watchdog", WDT_CLEAR, watchdog_counter);
    chk_byte("prescaler", PRE_CLEAR, watchdog_prescaler);
    chk_bit("clear_wdt", 1'h1, wdt_ctl.clear_wdt);
    chk_bit("clear_pre", 1'h1, wdt_ctl.clear_pre);
    tick(1);
    chk_bit("clear_wdt pulse end", 1'h0, wdt_ctl.clear_wdt);
    chk_bit("osc_run mid sequence", 1'h1, osc_run);
    tick(1);
    chk_bit("osc_run halted", 1'h0, osc_run);
    chk_bit("core_halted", 1'h1, core_halted);
    chk_byte("prescaler in halt", PRE_CLEAR, watchdog_prescaler);
    rd(REG_STATUS, d);
    chk_byte("status", 8'h05, d);
  endtask

  // Scenario: sticky event, enable, interrupt level and clear
  task automatic sc_irq();
    logic [DATA_W-1:0] d;
    chk_bit("irq disabled", 1'h0, irq);
    rd(REG_EVT, d);
    chk_byte("event sleep entered", 8'h01, d);
    wr(REG_EVT_EN, 8'h01);
    tick(1);
    chk_bit("irq enabled", 1'h1, irq);
    wr(REG_EVT_CLR, 8'h01);
    tick(1);
    chk_bit("irq cleared", 1'h0, irq);
  endtask

  // Scenario: software wake through the control register
  task automatic sc_wake();
    logic [DATA_W-1:0] d;
    wr(REG_CTRL, 8'h01);
    tick(1);
    chk_bit("osc_run after wake", 1'h1, osc_run);
    chk_bit("core_halted after wake", 1'h0, core_halted);
    rd(REG_EVT, d);
    chk_byte("event woke", 8'h02, d);
    chk_bit("irq masked wake", 1'h0, irq);
    tick(20);
    chk_flags("flags kept after wake", FLAGS_SLEPT);
  endtask

  initial begin
    sc_reset(9);
    sc_foreign();
    sc_sleep();
    sc_irq();
    sc_wake();
    sc_sleep();
    sc_reset(2);
    conclude;
  end
endmodule // slpx_core_bench
`default_nettype wire
